// ==== verilog/fsrc_pkg.sv ====
// Purpose: shared constants for flash suspend/resume control
// Assumes: one 25 MHz clock shared by both ends
// Notes:   times are in ns, cycle counts derived from the clock period
package fsrc_pkg;
	localparam int          CLK_PERIOD_NS     = 40;
	localparam logic [7:0]  CMD_ERASE_SUSPEND = 8'h75;
	localparam logic [7:0]  CMD_ERASE_RESUME  = 8'h7a;
	localparam logic [7:0]  CMD_PROG_SUSPEND  = 8'h85;
	localparam logic [7:0]  CMD_PROG_RESUME   = 8'h8a;
	localparam logic [7:0]  CMD_READ_STATUS   = 8'h05;
	localparam logic [7:0]  CMD_PROG_START    = 8'h02;
	localparam logic [7:0]  CMD_ERASE_START   = 8'hd8;
	localparam logic [7:0]  CMD_READ          = 8'h03;
	localparam int          STATUS_WIP_BIT    = 0;
	// latency fields: (count+1)*unit
	localparam int          SUSP_LAT_UNIT_NS  = 8000;
	localparam int          SUSP_LAT_COUNT    = 5;
	localparam int          SUSP_LAT_NS       = (SUSP_LAT_COUNT + 1) * SUSP_LAT_UNIT_NS;
	localparam int          RES_INT_UNIT_NS   = 64000;
	localparam int          RES_INT_COUNT     = 1;
	localparam int          RES_INT_NS        = (RES_INT_COUNT + 1) * RES_INT_UNIT_NS;
	// longest time rounds down, least time rounds up
	localparam int          SUSP_LAT_CYC      = SUSP_LAT_NS / CLK_PERIOD_NS;
	localparam int          RES_INT_CYC       = (RES_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SUSP_STOP_CYC     = 16;
	localparam int          PROG_OP_CYC       = 2000;
	localparam int          ERASE_OP_CYC      = 4000;
	localparam int          CNT_W             = 16;
	localparam int          ADDR_W            = 24;
	localparam int          PAGE_LSB          = 8;
	localparam int          SECT_LSB          = 16;
	typedef enum logic [1:0] {FSRC_OP_NONE, FSRC_OP_PROG, FSRC_OP_ERASE} fsrc_op_t;
endpackage : fsrc_pkg

// ==== verilog/fsrc_if.sv ====
// Purpose: command/answer link between host and flash ends
// Assumes: single clock, command taken on cmd_valid&cmd_ready
// Notes:   byte-level view of the serial instruction stream
`timescale 1ns/1ps
interface fsrc_if (
	input wire logic clk,
	input wire logic nrst
);
	import fsrc_pkg::*;
	logic              cmd_valid;
	logic              cmd_ready;
	logic [7:0]        cmd_code;
	logic [ADDR_W-1:0] cmd_addr;
	logic              rsp_valid;
	logic [7:0]        rsp_data;
	modport dev  (input clk, nrst, cmd_valid, cmd_code, cmd_addr, output cmd_ready, rsp_valid,
		rsp_data);
	modport host (input clk, nrst, cmd_ready, rsp_valid, rsp_data, output cmd_valid, cmd_code,
		cmd_addr);
endinterface : fsrc_if

// ==== verilog/fsrc_device.sv ====
// Purpose: flash-side suspend/resume sequencer with a status read
// Assumes: host keeps the resume-to-suspend and nesting limits
// Notes:   program/erase timing is a plain counter standing for the array
//
// Behaviour
// - byte 75h suspends running erase
// - byte 7Ah resumes suspended erase
// - byte 85h suspends running page program
// - byte 8Ah resumes suspended page program
// - host waits 128us before next erase suspend
// - program suspend completes within 48us
// - host waits 128us before next program suspend
// - no new erase while erase suspended
// - no read of suspended erase sector
// - no new program while program suspended
// - no program in suspended page
// - erase suspend completes within 48us
// - status read 05h, bit0 busy flag
`timescale 1ns/1ps
module fsrc_device (
	// link
	fsrc_if.dev                    lnk,
	// user side
	output logic                   op_busy,
	output logic                   erase_suspended,
	output logic                   prog_suspended,
	output logic                   op_done
);
	import fsrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// clock and reset travel on the link, so both ends share one domain
	wire clk_w  = lnk.clk;
	wire nrst_w = lnk.nrst;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {FSRC_IDLE, FSRC_RUN, FSRC_STOPPING, FSRC_SUSP} fsrc_state_t;

	fsrc_state_t       state_reg, state_next;
	fsrc_op_t          op_reg,    op_next;
	logic [CNT_W-1:0]  work_reg,  work_next;
	logic [CNT_W-1:0]  stop_reg,  stop_next;
	logic              rsp_v_reg, rsp_v_next;
	logic [7:0]        rsp_d_reg, rsp_d_next;
	logic              done_reg,  done_next;
	logic              busy_reg,  busy_next;
	logic              esusp_reg, esusp_next;
	logic              psusp_reg, psusp_next;

	////////////////////////////////////////////////////////////////////////
	// a suspend or resume byte only acts when its kind matches the held operation
	function automatic logic fsrc_kind_hit(
		input fsrc_op_t op,
		input logic     erase_hit,
		input logic     prog_hit
	);
		return (erase_hit && op == FSRC_OP_ERASE) || (prog_hit && op == FSRC_OP_PROG);
	endfunction : fsrc_kind_hit

	// state decode, shared by the status byte and the user flags
	function automatic logic fsrc_is_busy(input fsrc_state_t st);
		return st == FSRC_RUN || st == FSRC_STOPPING;
	endfunction : fsrc_is_busy

	function automatic logic fsrc_is_held(input fsrc_state_t st, input fsrc_op_t op,
		input fsrc_op_t kind);
		return st == FSRC_SUSP && op == kind;
	endfunction : fsrc_is_held

	////////////////////////////////////////////////////////////////////////
	wire       take       = lnk.cmd_valid && lnk.cmd_ready;
	wire       c_er_susp  = take && lnk.cmd_code == CMD_ERASE_SUSPEND;
	wire       c_er_res   = take && lnk.cmd_code == CMD_ERASE_RESUME;
	wire       c_pg_susp  = take && lnk.cmd_code == CMD_PROG_SUSPEND;
	wire       c_pg_res   = take && lnk.cmd_code == CMD_PROG_RESUME;
	// only an idle device takes a start, so nothing runs inside a suspend
	wire       c_pg_start = take && lnk.cmd_code == CMD_PROG_START;
	wire       c_er_start = take && lnk.cmd_code == CMD_ERASE_START;
	wire       c_status   = take && lnk.cmd_code == CMD_READ_STATUS;
	wire       susp_hit   = fsrc_kind_hit(op_reg, c_er_susp, c_pg_susp);
	wire       res_hit    = fsrc_kind_hit(op_reg, c_er_res, c_pg_res);
	wire       busy       = fsrc_is_busy(state_reg);
	// the stop time is short and fixed, well inside the worst-case latency
	wire       stop_end   = stop_reg == CNT_W'(SUSP_STOP_CYC - 1);
	wire       work_end   = work_reg == '0;
	// status is the state at the take edge, so a suspend still stopping reads busy
	wire [7:0] status_byte = 8'(busy) << STATUS_WIP_BIT;

	// cmd_ready is tied high: every byte is taken at the edge it is offered
	assign lnk.cmd_ready   = 1'b1;
	assign lnk.rsp_valid   = rsp_v_reg;
	assign lnk.rsp_data    = rsp_d_reg;
	assign op_busy         = busy_reg;
	assign erase_suspended = esusp_reg;
	assign prog_suspended  = psusp_reg;
	assign op_done         = done_reg;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		work_next  = work_reg;
		stop_next  = '0;
		unique case (state_reg)
			FSRC_IDLE: begin
				if (c_pg_start) begin
					state_next = FSRC_RUN;
					op_next    = FSRC_OP_PROG;
					work_next  = CNT_W'(PROG_OP_CYC - 1);
				end else if (c_er_start) begin
					state_next = FSRC_RUN;
					op_next    = FSRC_OP_ERASE;
					work_next  = CNT_W'(ERASE_OP_CYC - 1);
				end
			end
			FSRC_RUN: begin
				// a suspend wins over a finish in the same cycle
				if (susp_hit) begin
					state_next = FSRC_STOPPING;
				end else if (work_end) begin
					state_next = FSRC_IDLE;
					op_next    = FSRC_OP_NONE;
				end else begin
					work_next = work_reg - CNT_W'(1);
				end
			end
			FSRC_STOPPING: begin
				stop_next = stop_reg + CNT_W'(1);
				if (stop_end) begin
					state_next = FSRC_SUSP;
				end
			end
			FSRC_SUSP: begin
				// work_reg is kept, so the operation picks up where it stopped
				if (res_hit) begin
					state_next = FSRC_RUN;
				end
			end
			default: begin
				state_next = FSRC_IDLE;
				op_next    = FSRC_OP_NONE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// flags come from the next state, so they line up with the state register
	always_comb begin
		busy_next  = fsrc_is_busy(state_next);
		esusp_next = fsrc_is_held(state_next, op_next, FSRC_OP_ERASE);
		psusp_next = fsrc_is_held(state_next, op_next, FSRC_OP_PROG);
		done_next  = state_reg == FSRC_RUN && state_next == FSRC_IDLE;
		rsp_v_next = c_status;
		rsp_d_next = c_status ? status_byte : rsp_d_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// state and held operation
	always_ff @(posedge clk_w or negedge nrst_w) begin
		if (!nrst_w) begin
			state_reg <= FSRC_IDLE;
			op_reg    <= FSRC_OP_NONE;
		end else begin
			state_reg <= state_next;
			op_reg    <= op_next;
		end
	end

	// work left in the array and stop time
	always_ff @(posedge clk_w or negedge nrst_w) begin
		if (!nrst_w) begin
			work_reg <= '0;
			stop_reg <= '0;
		end else begin
			work_reg <= work_next;
			stop_reg <= stop_next;
		end
	end

	// status answer
	always_ff @(posedge clk_w or negedge nrst_w) begin
		if (!nrst_w) begin
			rsp_v_reg <= 1'b0;
			rsp_d_reg <= 8'h00;
		end else begin
			rsp_v_reg <= rsp_v_next;
			rsp_d_reg <= rsp_d_next;
		end
	end

	// user flags
	always_ff @(posedge clk_w or negedge nrst_w) begin
		if (!nrst_w) begin
			busy_reg  <= 1'b0;
			esusp_reg <= 1'b0;
			psusp_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			busy_reg  <= busy_next;
			esusp_reg <= esusp_next;
			psusp_reg <= psusp_next;
			done_reg  <= done_next;
		end
	end
endmodule : fsrc_device

// ==== verilog/fsrc_host.sv ====
// Purpose: host-side controller issuing suspend/resume and status polls
// Assumes: device answers status one cycle after the command
// Notes:   refused user requests are dropped and flagged for one cycle
`timescale 1ns/1ps
module fsrc_host (
	// link
	fsrc_if.host                             lnk,
	// user requests
	input  wire logic                        req_valid,
	input  wire logic [7:0]                  req_code,
	input  wire logic [fsrc_pkg::ADDR_W-1:0] req_addr,
	// user answers
	output logic                             req_refused,
	output logic                             status_valid,
	output logic                             status_busy
);
	import fsrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic              er_susp_reg, pg_susp_reg;
	logic [ADDR_W-1:0] er_addr_reg, pg_addr_reg;
	logic [CNT_W-1:0]  er_gap_reg,  pg_gap_reg;
	logic              cv_reg;
	logic [7:0]        cc_reg;
	logic [ADDR_W-1:0] ca_reg;
	logic              ref_reg, sv_reg, sb_reg;

	wire clk  = lnk.clk;
	wire nrst = lnk.nrst;
	wire same_sect = req_addr[ADDR_W-1:SECT_LSB] == er_addr_reg[ADDR_W-1:SECT_LSB];
	wire same_page = req_addr[ADDR_W-1:PAGE_LSB] == pg_addr_reg[ADDR_W-1:PAGE_LSB];
	wire bad_er_s  = req_code == CMD_ERASE_SUSPEND && er_gap_reg != '0;
	wire bad_pg_s  = req_code == CMD_PROG_SUSPEND && pg_gap_reg != '0;
	wire bad_er    = req_code == CMD_ERASE_START && er_susp_reg;
	wire bad_rd    = req_code == CMD_READ && er_susp_reg && same_sect;
	wire bad_pg    = req_code == CMD_PROG_START && pg_susp_reg;
	wire bad_pgpg  = req_code == CMD_PROG_START && pg_susp_reg && same_page;
	wire refuse    = bad_er_s | bad_pg_s | bad_er | bad_rd | bad_pg | bad_pgpg;
	wire issue     = req_valid && !refuse && !cv_reg;
	wire sent      = cv_reg && lnk.cmd_ready;

	assign lnk.cmd_valid = cv_reg;
	assign lnk.cmd_code  = cc_reg;
	assign lnk.cmd_addr  = ca_reg;
	assign req_refused   = ref_reg;
	assign status_valid  = sv_reg;
	assign status_busy   = sb_reg;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cv_reg      <= 1'b0;
			cc_reg      <= 8'h00;
			ca_reg      <= '0;
			ref_reg     <= 1'b0;
			sv_reg      <= 1'b0;
			sb_reg      <= 1'b0;
			er_susp_reg <= 1'b0;
			pg_susp_reg <= 1'b0;
			er_addr_reg <= '0;
			pg_addr_reg <= '0;
			er_gap_reg  <= '0;
			pg_gap_reg  <= '0;
		end else begin
			ref_reg <= req_valid && refuse && !cv_reg;
			sv_reg  <= lnk.rsp_valid;
			sb_reg  <= lnk.rsp_valid ? lnk.rsp_data[STATUS_WIP_BIT] : sb_reg;
			if (issue) begin
				cv_reg <= 1'b1;
				cc_reg <= req_code;
				ca_reg <= req_addr;
			end else if (sent) begin
				cv_reg <= 1'b0;
			end
			er_gap_reg <= er_gap_reg - CNT_W'(er_gap_reg != '0);
			pg_gap_reg <= pg_gap_reg - CNT_W'(pg_gap_reg != '0);
			if (sent) begin
				unique case (cc_reg)
					CMD_ERASE_START:   er_addr_reg <= ca_reg;
					CMD_PROG_START:    pg_addr_reg <= ca_reg;
					CMD_ERASE_SUSPEND: er_susp_reg <= 1'b1;
					CMD_PROG_SUSPEND:  pg_susp_reg <= 1'b1;
					CMD_ERASE_RESUME: begin
						er_susp_reg <= 1'b0;
						er_gap_reg  <= CNT_W'(RES_INT_CYC);
					end
					CMD_PROG_RESUME: begin
						pg_susp_reg <= 1'b0;
						pg_gap_reg  <= CNT_W'(RES_INT_CYC);
					end
					default: ;
				endcase
			end
		end
	end
endmodule : fsrc_host

// ==== testbench/fsrc_asserts.sv ====
// Purpose: link checks for suspend/resume
// Assumes: one clock; a command counts at an edge with valid and ready
// Notes:   gaps count from the link take
`timescale 1ns/1ps
module fsrc_asserts (
	// link
	input wire logic                         clk,
	input wire logic                         nrst,
	input wire logic                         cmd_valid,
	input wire logic                         cmd_ready,
	input wire logic [7:0]                   cmd_code,
	input wire logic [fsrc_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic                         rsp_valid,
	input wire logic [7:0]                   rsp_data
);
	import fsrc_pkg::*;
	// both gaps are measured between link takes, full interval
	localparam int GAP_MIN = RES_INT_CYC;
	////////////////////////////////
	wire tk    = cmd_valid && cmd_ready;
	wire tk_es = tk && cmd_code == CMD_ERASE_SUSPEND;
	wire tk_er = tk && cmd_code == CMD_ERASE_RESUME;
	wire tk_ps = tk && cmd_code == CMD_PROG_SUSPEND;
	wire tk_pr = tk && cmd_code == CMD_PROG_RESUME;
	wire tk_ee = tk && cmd_code == CMD_ERASE_START;
	wire tk_pp = tk && cmd_code == CMD_PROG_START;
	wire tk_rd = tk && cmd_code == CMD_READ;
	logic [CNT_W-1:0] egap_reg, pgap_reg, slat_reg;
	logic [7:0]       sect_reg;
	logic             es_reg, ps_reg, halt_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			egap_reg <= CNT_W'(RES_INT_CYC);
			pgap_reg <= CNT_W'(RES_INT_CYC);
			slat_reg <= '0;
			{es_reg, ps_reg, halt_reg} <= 3'h0;
			sect_reg <= 8'h00;
		end else begin
			egap_reg <= tk_er ? '0 : egap_reg + CNT_W'(egap_reg < RES_INT_CYC);
			pgap_reg <= tk_pr ? '0 : pgap_reg + CNT_W'(pgap_reg < RES_INT_CYC);
			slat_reg <= tk_es || tk_ps ? '0 : slat_reg + CNT_W'(slat_reg <= SUSP_LAT_CYC);
			es_reg <= tk_es || (es_reg && !tk_er);
			ps_reg <= tk_ps || (ps_reg && !tk_pr);
			halt_reg <= tk_es || tk_ps || (halt_reg && !(tk_er || tk_pr || tk_ee || tk_pp));
			if (tk_ee) sect_reg <= cmd_addr[ADDR_W-1:SECT_LSB];
		end
	end
	////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence stat_req; tk && cmd_code == CMD_READ_STATUS; endsequence
	sequence stat_ans; rsp_valid ##1 !rsp_valid; endsequence
	status_answer_a: assert property (stat_req |=> stat_ans)
		else $error("status answer missing");
	answer_cause_a: assert property (rsp_valid |-> $past(tk) && $past(cmd_code) == CMD_READ_STATUS)
		else $error("answer without status read");
	erase_gap_a: assert property (tk_es |-> egap_reg >= GAP_MIN)
		else $error("erase suspend too soon");
	prog_gap_a: assert property (tk_ps |-> pgap_reg >= GAP_MIN)
		else $error("program suspend too soon");
	erase_nest_a: assert property (es_reg |-> !tk_ee)
		else $error("erase while erase held");
	sect_read_a: assert property (es_reg && tk_rd |-> cmd_addr[ADDR_W-1:SECT_LSB] != sect_reg)
		else $error("read in held sector");
	prog_nest_a: assert property (ps_reg |-> !tk_pp)
		else $error("program while program held");
	stop_time_a: assert property (halt_reg && slat_reg > SUSP_LAT_CYC && rsp_valid |-> !rsp_data[STATUS_WIP_BIT])
		else $error("suspend too slow");
endmodule : fsrc_asserts

// ==== testbench/flash_suspend_resume_control_tb.sv ====
// Purpose: host user side driven, device flags watched
// Assumes: host and device joined by one link
// Notes:   lengths are fixed in the package
`timescale 1ns/1ps
module flash_suspend_resume_control_tb;
	import fsrc_pkg::*;
	logic              clk, nrst, req_valid, req_refused, status_valid, status_busy;
	logic              op_busy, erase_suspended, prog_suspended, op_done;
	logic [7:0]        req_code;
	logic [ADDR_W-1:0] req_addr;
	wire  [2:0]        flags = {op_done, prog_suspended, erase_suspended};
	int                error_cnt = 0, n_checks = 0, cyc = 0;
	fsrc_if lnk (.clk(clk), .nrst(nrst));
	fsrc_host i_fsrc_host (.lnk(lnk.host), .req_valid(req_valid), .req_code(req_code),
		.req_addr(req_addr), .req_refused(req_refused), .status_valid(status_valid),
		.status_busy(status_busy));
	fsrc_device i_fsrc_device (.lnk(lnk.dev), .op_busy(op_busy),
		.erase_suspended(erase_suspended), .prog_suspended(prog_suspended), .op_done(op_done));
	fsrc_asserts i_fsrc_asserts (.clk(clk), .nrst(nrst), .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .cmd_code(lnk.cmd_code), .cmd_addr(lnk.cmd_addr),
		.rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));
	////////////////////////////////
	task automatic check(input string nm, input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %b seen %b", nm, exp, seen);
		end
	endtask : check
	task automatic send(input logic [7:0] code, input logic [ADDR_W-1:0] addr, input logic rf);
		@(negedge clk);
		req_valid = 1'b1;
		req_code = code;
		req_addr = addr;
		@(negedge clk);
		req_valid = 1'b0;
		check("refused", req_refused, rf);
		@(negedge clk);
	endtask : send
	task automatic poll(input logic busy);
		send(CMD_READ_STATUS, '0, 1'b0);
		@(negedge clk);
		check("status_valid", status_valid, 1'b1);
		check("busy", status_busy, busy);
	endtask : poll
	// bounded wait, so a stuck flag ends as a mismatch
	task automatic wait_flag(input int b, input int lim);
		for (int k = 0; k < lim && flags[b] !== 1'b1; k++) @(negedge clk);
		check("flag", flags[b], 1'b1);
	endtask : wait_flag
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		{nrst, req_valid, req_code, req_addr} = '0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		poll(1'b0);
		send(CMD_ERASE_START, 24'h120000, 1'b0);
		poll(1'b1);
		send(CMD_ERASE_SUSPEND, '0, 1'b0);
		wait_flag(0, SUSP_LAT_CYC);
		repeat (SUSP_LAT_CYC) @(negedge clk);
		poll(1'b0);
		send(CMD_ERASE_START, 24'h300000, 1'b1);
		send(CMD_READ, 24'h12ff00, 1'b1);
		send(CMD_READ, 24'h130000, 1'b0);
		send(CMD_ERASE_RESUME, '0, 1'b0);
		check("erase_suspended", erase_suspended, 1'b0);
		send(CMD_ERASE_SUSPEND, '0, 1'b1);
		repeat (RES_INT_CYC) @(negedge clk);
		send(CMD_ERASE_SUSPEND, '0, 1'b0);
		wait_flag(0, SUSP_LAT_CYC);
		send(CMD_ERASE_RESUME, '0, 1'b0);
		poll(1'b1);
		wait_flag(2, ERASE_OP_CYC);
		poll(1'b0);
		send(CMD_PROG_START, 24'h000100, 1'b0);
		send(CMD_PROG_SUSPEND, '0, 1'b0);
		wait_flag(1, SUSP_LAT_CYC);
		send(CMD_PROG_START, 24'h200000, 1'b1);
		send(CMD_PROG_START, 24'h000180, 1'b1);
		send(CMD_PROG_RESUME, '0, 1'b0);
		poll(1'b1);
		check("op_busy", op_busy, 1'b1);
		send(CMD_PROG_SUSPEND, '0, 1'b1);
		wait_flag(2, PROG_OP_CYC);
		complete_run;
	end
endmodule : flash_suspend_resume_control_tb
